//--- design/genlock_regs_pkg.sv
// Purpose: constants and types for the genlock offset and status register slice
// Assumes: AXI4-Lite, 32-bit data, byte address = 4 * register index
// Notes: indices are word indices, not byte addresses
// Operation
// - output vertical timing delayed by 16-bit line count; resets to zero
// - vertical delay sampled once per field and forwarded at that moment
// - output clock and data phase shifted by 16-bit increment count
// - 16-bit tolerance bounds reference hsync deviation before lock loss; resets 000Bh
// - status bit 4 shows hsync polarity, zero with no reference
// - status bit 3 shows vsync polarity, zero without reference or digital blanking
// - status bit 2 shows blanking versus sync timing, zero without reference
// - status bit 1 shows audio lock; always high in variant without audio
// - status bit 0 high while video clock locked to hsync reference
// - nonzero 32-bit numerator sets video clock to reference ratio numerator
// - numerator low half at lower index, high half at next index
// - new numerator applied only on the ratio_commit_i strobe or on a standard load
// - numerator resets to the NUM_DEFAULT parameter and takes the selected standard's value on a standard load
// - horizontal delay in pixels, sampled once per field as well
// - nonzero denominator, split likewise, committed the same way as numerator
package genlock_regs_pkg;
   localparam logic [7:0] IDX_HDELAY = 8'h1B;
   localparam logic [7:0] IDX_VDELAY = 8'h1C;
   localparam logic [7:0] IDX_PHASE = 8'h1D;
   localparam logic [7:0] IDX_TOL = 8'h1E;
   localparam logic [7:0] IDX_STATUS = 8'h1F;
   localparam logic [7:0] IDX_NUM_LO = 8'h20;
   localparam logic [7:0] IDX_NUM_HI = 8'h21;
   localparam logic [7:0] IDX_DEN_LO = 8'h22;
   localparam logic [7:0] IDX_DEN_HI = 8'h23;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
   localparam logic [15:0] TOL_RESET = 16'h000B;
   localparam logic [15:0] DELAY_RESET = 16'h0000;
   localparam int ST_HPOL = 4;
   localparam int ST_VPOL = 3;
   localparam int ST_BLANK = 2;
   localparam int ST_ALOCK = 1;
   localparam int ST_VLOCK = 0;
   localparam int IRQ_FIELD = 0;
   localparam int IRQ_VLOCK_LOST = 1;
   localparam int IRQ_COMMIT = 2;
   localparam int IRQ_W = 3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic ref_present;
      logic hsync_pos;
      logic vsync_pos;
      logic blank_timing;
      logic digital_blank;
      logic audio_lock;
      logic video_lock;
   } ref_detect_type;

   typedef struct packed {
      logic [15:0] h_delay;
      logic [15:0] v_delay;
   } offset_type;

   typedef struct packed {
      logic [31:0] num;
      logic [31:0] den;
   } ratio_type;
endpackage

//--- design/genlock_offset_status_regs.sv
// Purpose: register slice holding offsets, tolerance, detect flags and clock ratio
// Assumes: single clock from the 27MHz-derived core clock; detect inputs on same clock
// Notes: unmapped addresses answer SLVERR
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module genlock_offset_status_regs #(
   parameter bit HAS_AUDIO = 1'b1,
   parameter logic [31:0] NUM_DEFAULT = 32'h0000_0001,
   parameter logic [31:0] DEN_DEFAULT = 32'h0000_0001
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [31:0] std_num_default_i,
   input wire logic [31:0] std_den_default_i,
   input wire logic std_load_i,
   input wire logic field_start_i,
   input wire logic ratio_commit_i,
   input wire genlock_regs_pkg::ref_detect_type detect_i,
   output genlock_regs_pkg::offset_type offset_o,
   output logic [15:0] phase_shift_o,
   output logic [15:0] ref_tolerance_o,
   output genlock_regs_pkg::ratio_type ratio_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // write channel capture
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;

   assign s_axi_awready_o = !aw_held_r && !bvalid_r;
   assign s_axi_wready_o = !w_held_r && !bvalid_r;

   wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
   wire w_take = s_axi_wvalid_i && s_axi_wready_o;
   wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr_i;
   wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata_i;
   wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb_i;
   wire wr_fire = (aw_held_r || aw_take) && (w_held_r || w_take);
   wire [5:0] wr_idx = wr_addr[7:2];

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
   endfunction

   function automatic logic idx_mapped(input logic [5:0] i);
      idx_mapped = (i >= genlock_regs_pkg::IDX_HDELAY[5:0] &&
                    i <= genlock_regs_pkg::IDX_DEN_HI[5:0]) ||
                   i == genlock_regs_pkg::IDX_IRQ_STAT[5:0] ||
                   i == genlock_regs_pkg::IDX_IRQ_MASK[5:0];
   endfunction

   function automatic logic hit(input logic [5:0] i, input logic [7:0] idx);
      hit = (i == idx[5:0]);
   endfunction

   wire wr_ok = wr_fire && idx_mapped(wr_idx);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'b00;
      end else begin
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= idx_mapped(wr_idx) ? genlock_regs_pkg::RESP_OKAY
                                          : genlock_regs_pkg::RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held_r <= 1'b1;
               aw_addr_r <= s_axi_awaddr_i;
            end
            if (w_take) begin
               w_held_r <= 1'b1;
               w_data_r <= s_axi_wdata_i;
               w_strb_r <= s_axi_wstrb_i;
            end
            if (bvalid_r && s_axi_bready_i) begin
               bvalid_r <= 1'b0;
            end
         end
      end
   end

   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;

   ////////////////////////////////////////////////////////////////////////////
   // software-visible registers
   logic [15:0] h_delay_r;
   logic [15:0] v_delay_r;
   logic [15:0] phase_r;
   logic [15:0] tol_r;
   logic [31:0] num_r;
   logic [31:0] den_r;

   wire we_h = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_HDELAY);
   wire we_v = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_VDELAY);
   wire we_ph = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_PHASE);
   wire we_tol = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_TOL);
   wire we_nl = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_NUM_LO);
   wire we_nh = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_NUM_HI);
   wire we_dl = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_DEN_LO);
   wire we_dh = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_DEN_HI);
   wire we_ist = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_IRQ_STAT);
   wire we_imk = wr_ok && hit(wr_idx, genlock_regs_pkg::IDX_IRQ_MASK);

   // numerator and denominator reset to NUM_DEFAULT and DEN_DEFAULT; a standard load sets them from the standard
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         h_delay_r <= genlock_regs_pkg::DELAY_RESET;
         v_delay_r <= genlock_regs_pkg::DELAY_RESET;
         phase_r <= 16'h0000;
         tol_r <= genlock_regs_pkg::TOL_RESET;
         num_r <= NUM_DEFAULT;
         den_r <= DEN_DEFAULT;
      end else begin
         if (we_h) h_delay_r <= merge16(h_delay_r, wr_data, wr_strb);
         if (we_v) v_delay_r <= merge16(v_delay_r, wr_data, wr_strb);
         if (we_ph) phase_r <= merge16(phase_r, wr_data, wr_strb);
         if (we_tol) tol_r <= merge16(tol_r, wr_data, wr_strb);
         if (std_load_i) begin
            num_r <= std_num_default_i;
            den_r <= std_den_default_i;
         end else begin
            if (we_nl) num_r[15:0] <= merge16(num_r[15:0], wr_data, wr_strb);
            if (we_nh) num_r[31:16] <= merge16(num_r[31:16], wr_data, wr_strb);
            if (we_dl) den_r[15:0] <= merge16(den_r[15:0], wr_data, wr_strb);
            if (we_dh) den_r[31:16] <= merge16(den_r[31:16], wr_data, wr_strb);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // values forwarded to the timing and clock logic
   logic [15:0] h_live_r;
   logic [15:0] v_live_r;
   logic [31:0] num_live_r;
   logic [31:0] den_live_r;
   // zero would stall the synthesiser, so only nonzero values are committed
   // a standard load commits the incoming defaults, not the registers it overwrites
   wire [31:0] num_src = std_load_i ? std_num_default_i : num_r;
   wire [31:0] den_src = std_load_i ? std_den_default_i : den_r;
   wire num_ok = (num_src != 32'h0000_0000);
   wire den_ok = (den_src != 32'h0000_0000);
   wire commit_go = ratio_commit_i || std_load_i;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         h_live_r <= genlock_regs_pkg::DELAY_RESET;
         v_live_r <= genlock_regs_pkg::DELAY_RESET;
         num_live_r <= NUM_DEFAULT;
         den_live_r <= DEN_DEFAULT;
      end else begin
         if (field_start_i) begin
            h_live_r <= h_delay_r;
            v_live_r <= v_delay_r;
         end
         if (commit_go && num_ok) num_live_r <= num_src;
         if (commit_go && den_ok) den_live_r <= den_src;
      end
   end

   assign offset_o = '{h_delay: h_live_r, v_delay: v_live_r};
   assign phase_shift_o = phase_r;
   assign ref_tolerance_o = tol_r;
   assign ratio_o = '{num: num_live_r, den: den_live_r};

   ////////////////////////////////////////////////////////////////////////////
   // status bits
   wire pres = detect_i.ref_present;
   wire [15:0] status_w = {11'h000,
                           pres && detect_i.hsync_pos,
                           pres && !detect_i.digital_blank && detect_i.vsync_pos,
                           pres && detect_i.blank_timing,
                           HAS_AUDIO ? detect_i.audio_lock : 1'b1,
                           detect_i.video_lock};

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: field start, video lock lost, ratio committed
   logic [genlock_regs_pkg::IRQ_W-1:0] irq_stat_r;
   logic [genlock_regs_pkg::IRQ_W-1:0] irq_mask_r;
   logic vlock_d_r;
   wire [genlock_regs_pkg::IRQ_W-1:0] irq_ev = {commit_go,
                                                vlock_d_r && !detect_i.video_lock,
                                                field_start_i};
   wire [genlock_regs_pkg::IRQ_W-1:0] irq_clr = we_ist ?
      wr_data[genlock_regs_pkg::IRQ_W-1:0] : {genlock_regs_pkg::IRQ_W{1'b0}};

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         vlock_d_r <= 1'b0;
      end else begin
         vlock_d_r <= detect_i.video_lock;
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev; // set wins over clear
         if (we_imk && wr_strb[0]) irq_mask_r <= wr_data[genlock_regs_pkg::IRQ_W-1:0];
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////////////////
   // read channel
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   assign s_axi_arready_o = !rvalid_r;
   wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
   wire [5:0] rd_idx = s_axi_araddr_i[7:2];

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(rd_idx, genlock_regs_pkg::IDX_HDELAY)) rd_mux = {16'h0000, h_delay_r};
      if (hit(rd_idx, genlock_regs_pkg::IDX_VDELAY)) rd_mux = {16'h0000, v_delay_r};
      if (hit(rd_idx, genlock_regs_pkg::IDX_PHASE)) rd_mux = {16'h0000, phase_r};
      if (hit(rd_idx, genlock_regs_pkg::IDX_TOL)) rd_mux = {16'h0000, tol_r};
      if (hit(rd_idx, genlock_regs_pkg::IDX_STATUS)) rd_mux = {16'h0000, status_w};
      if (hit(rd_idx, genlock_regs_pkg::IDX_NUM_LO)) rd_mux = {16'h0000, num_r[15:0]};
      if (hit(rd_idx, genlock_regs_pkg::IDX_NUM_HI)) rd_mux = {16'h0000, num_r[31:16]};
      if (hit(rd_idx, genlock_regs_pkg::IDX_DEN_LO)) rd_mux = {16'h0000, den_r[15:0]};
      if (hit(rd_idx, genlock_regs_pkg::IDX_DEN_HI)) rd_mux = {16'h0000, den_r[31:16]};
      if (hit(rd_idx, genlock_regs_pkg::IDX_IRQ_STAT)) rd_mux = {29'h0, irq_stat_r};
      if (hit(rd_idx, genlock_regs_pkg::IDX_IRQ_MASK)) rd_mux = {29'h0, irq_mask_r};
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= 2'b00;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= idx_mapped(rd_idx) ? genlock_regs_pkg::RESP_OKAY
                                       : genlock_regs_pkg::RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready_i) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;

endmodule
`default_nettype wire

//--- dv/genlock_offset_status_regs_chk.sv
// Purpose: concurrent checks on the ports of the genlock register slice
// Assumes: one clock, synchronous active-high reset
// Notes: status bits are judged one cycle after the read address is taken
`timescale 1ns/1ns
`default_nettype none
module genlock_offset_status_regs_chk #(
   parameter bit HAS_AUDIO = 1'b1
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic field_start_i,
   input wire logic ratio_commit_i,
   input wire logic std_load_i,
   input wire genlock_regs_pkg::ref_detect_type detect_i,
   input wire genlock_regs_pkg::offset_type offset_o,
   input wire logic [15:0] ref_tolerance_o,
   input wire genlock_regs_pkg::ratio_type ratio_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////////////////////////////////////////////
   sequence st_rd;
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 8'h7C;
   endsequence
   sequence wr_both;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   reset_vals_a: assert property ($past(srst_i) |-> ref_tolerance_o == 16'h000B)
      else $error("tolerance output wrong after reset");
   delay_field_a: assert property (!field_start_i |=> $stable(offset_o))
      else $error("live delays moved without a field start");
   ratio_commit_a: assert property (!ratio_commit_i && !std_load_i |=> $stable(ratio_o))
      else $error("live ratio moved without a commit");
   st_hpol_a: assert property (st_rd |=> s_axi_rdata_o[4] ==
      $past(detect_i.hsync_pos && detect_i.ref_present)) else $error("hsync polarity bit wrong");
   st_vpol_a: assert property (st_rd |=> s_axi_rdata_o[3] == $past(detect_i.vsync_pos &&
      detect_i.ref_present && !detect_i.digital_blank)) else $error("vsync polarity bit wrong");
   st_blank_a: assert property (st_rd |=> s_axi_rdata_o[2] ==
      $past(detect_i.blank_timing && detect_i.ref_present)) else $error("blanking bit wrong");
   st_alock_a: assert property (st_rd |=> s_axi_rdata_o[1] ==
      ($past(detect_i.audio_lock) || !HAS_AUDIO)) else $error("audio lock bit wrong");
   st_vlock_a: assert property (st_rd |=> s_axi_rdata_o[0] == $past(detect_i.video_lock))
      else $error("video lock bit wrong");
   st_resv_a: assert property (st_rd |=> s_axi_rvalid_o && s_axi_rdata_o[31:5] == 27'h0)
      else $error("reserved status bits not zero");
   wr_resp_a: assert property (wr_both |=> s_axi_bvalid_o)
      else $error("write response late");
   rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped before taken");
endmodule
bind genlock_offset_status_regs genlock_offset_status_regs_chk #(.HAS_AUDIO(HAS_AUDIO)) chk_i (
   .clk_sys_i(clk_sys_i),
   .srst_i(srst_i),
   .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_araddr_i(s_axi_araddr_i),
   .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o),
   .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i),
   .field_start_i(field_start_i),
   .ratio_commit_i(ratio_commit_i),
   .std_load_i(std_load_i),
   .detect_i(detect_i),
   .offset_o(offset_o),
   .ref_tolerance_o(ref_tolerance_o),
   .ratio_o(ratio_o)
);
`default_nettype wire

//--- dv/genlock_offset_status_regs_bench.sv
// Purpose: directed bench for the genlock register slice
// Assumes: irq mask bit high enables the matching status bit
// Notes: detect inputs are driven straight, no synchroniser in the way
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin $display("Error %s exp %h got %h", nm, e, g); num_errors++; end end
module genlock_offset_status_regs_bench;
   localparam logic [31:0] NUM_DEF = 32'h1234_5678;
   logic clk_sys_i = 1'b0, srst_i = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, std_load = 1'b0, fld = 1'b0, commit = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, num_in = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, resp;
   logic [15:0] phase, tol;
   genlock_regs_pkg::ref_detect_type det = '0;
   genlock_regs_pkg::offset_type offs;
   genlock_regs_pkg::ratio_type ratio;
   genlock_regs_pkg::ref_detect_type tbl [4] = '{7'h7F, 7'h76, 7'h3B, 7'h51};
   int num_errors = 0, n_checks = 0;
   genlock_offset_status_regs #(.NUM_DEFAULT(NUM_DEF)) uut (.clk_sys_i(clk_sys_i),
      .srst_i(srst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .std_num_default_i(num_in), .std_den_default_i(32'h0), .std_load_i(std_load),
      .field_start_i(fld), .ratio_commit_i(commit), .detect_i(det), .offset_o(offs),
      .phase_shift_o(phase), .ref_tolerance_o(tol), .ratio_o(ratio), .irq_o(irq));
   always #25 clk_sys_i = ~clk_sys_i;
   ////////////////////////////////////////////////////////////////////////////////
   // each bus task starts on a fresh edge so a strobe is never set twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   // rready comes late on purpose so read data must stand
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
         if (n == 2) rready <= 1'b1;
      end while (!(rvalid === 1'b1 && rready === 1'b1));
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   function automatic logic [31:0] st_exp(genlock_regs_pkg::ref_detect_type d);
      return {27'h0, d.hsync_pos & d.ref_present, d.vsync_pos & d.ref_present & ~d.digital_blank,
         d.blank_timing & d.ref_present, d.audio_lock, d.video_lock};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd_reg(8'h78, rd);
      `CHK("tol", 32'h0000_000B, rd)
      `CHK("tol_out", genlock_regs_pkg::TOL_RESET, tol)
      rd_reg(8'h70, rd);
      `CHK("vdelay", 32'h0, rd)
      `CHK("ratio_num", NUM_DEF, ratio.num)
      $display("test reset done");
   endtask
   task automatic t_delay;
      wr(8'h70, 32'h0000_0123);
      wr(8'h6C, 32'h0000_0045);
      wr(8'h74, 32'h0000_ABCD);
      rd_reg(8'h70, rd);
      `CHK("vdelay_rd", 32'h0000_0123, rd)
      `CHK("v_hold", 16'h0000, offs.v_delay)
      `CHK("phase", 16'hABCD, phase)
      fld <= 1'b1;
      @(posedge clk_sys_i);
      fld <= 1'b0;
      @(posedge clk_sys_i);
      `CHK("v_live", 16'h0123, offs.v_delay)
      `CHK("h_live", 16'h0045, offs.h_delay)
      wr(8'h74, 32'h0);
      `CHK("phase_zero", 16'h0000, phase)
      $display("test delay done");
   endtask
   task automatic t_ratio;
      wr(8'h80, 32'h0000_5678);
      wr(8'h84, 32'h0000_9ABC);
      wr(8'h88, 32'h0);
      wr(8'h8C, 32'h0);
      rd_reg(8'h84, rd);
      `CHK("num_hi", 32'h0000_9ABC, rd)
      `CHK("num_hold", NUM_DEF, ratio.num)
      commit <= 1'b1;
      @(posedge clk_sys_i);
      commit <= 1'b0;
      num_in <= 32'h0000_0FA0;
      @(posedge clk_sys_i);
      `CHK("num_live", 32'h9ABC_5678, ratio.num)
      `CHK("den_keep", 32'h0000_0001, ratio.den)
      std_load <= 1'b1;
      @(posedge clk_sys_i);
      std_load <= 1'b0;
      rd_reg(8'h80, rd);
      `CHK("num_std", 32'h0000_0FA0, rd)
      `CHK("num_std_live", 32'h0000_0FA0, ratio.num)
      $display("test ratio done");
   endtask
   task automatic t_status;
      for (int i = 0; i < 4; i++) begin
         det <= tbl[i];
         rd_reg(8'h7C, rd);
         `CHK("status", st_exp(tbl[i]), rd)
      end
      wr(8'h7C, 32'h0000_FFFF);
      `CHK("status_wr_resp", genlock_regs_pkg::RESP_OKAY, resp)
      rd_reg(8'h7C, rd);
      `CHK("status_ro", st_exp(tbl[3]), rd)
      rd_reg(8'hF0, rd);
      `CHK("unmapped", genlock_regs_pkg::RESP_SLVERR, resp)
      $display("test status done");
   endtask
   task automatic t_irq;
      wr(8'hC0, 32'h0000_0007);
      fld <= 1'b1;
      @(posedge clk_sys_i);
      fld <= 1'b0;
      rd_reg(8'hC0, rd);
      `CHK("irq_stat", 32'h0000_0001, rd)
      `CHK("irq_masked", 1'b0, irq)
      wr(8'hC4, 32'h0000_0001);
      `CHK("irq_on", 1'b1, irq)
      wr(8'hC0, 32'h0000_0001);
      `CHK("irq_clr", 1'b0, irq)
      $display("test irq done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      t_reset();
      t_delay();
      t_ratio();
      t_status();
      t_irq();
      report_and_stop();
   end
   // the tests need well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      num_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
